// *** shared/uart_mode_pkg.sv ***
// constants, field layouts and carrier types for the channel mode registers
package uart_mode_pkg;

	// register addresses on the parallel bus
	localparam logic [3:0] addr_mode_a = 4'h0;
	localparam logic [3:0] addr_mode_b = 4'h8;

	// mode pointer values seen on the bus side
	localparam logic ptr_mode0 = 1'b0;
	localparam logic ptr_mode1 = 1'b1;

	// mode register zero layout
	localparam int mr0_watchdog_bit = 7;
	localparam int mr0_rx_thr_bit = 6;
	localparam int mr0_tx_thr_hi = 5;
	localparam int mr0_tx_thr_lo = 4;
	localparam int mr0_dont_care_bit = 3;
	localparam int mr0_ext2_bit = 2;
	localparam int mr0_test_bit = 1;
	localparam int mr0_ext1_bit = 0;

	// mode register one layout
	localparam int mr1_rts_bit = 7;
	localparam int mr1_rx_int_bit = 6;
	localparam int mr1_err_mode_bit = 5;
	localparam int mr1_par_hi = 4;
	localparam int mr1_par_lo = 3;
	localparam int mr1_par_type_bit = 2;
	localparam int mr1_len_hi = 1;
	localparam int mr1_len_lo = 0;

	// reset values and read masks
	localparam logic [7:0] mr0_reset = 8'h00;
	localparam logic [7:0] mr1_reset = 8'h00;
	localparam logic [7:0] mr0_read_one_a = 8'h08;
	localparam logic [7:0] mr0_read_one_b = 8'h0f;
	localparam logic [7:0] mr0_store_a = 8'hf7;
	localparam logic [7:0] mr0_store_b = 8'hf0;
	localparam logic [7:0] unmapped_read = 8'h00;

	// fewest data bits per character
	localparam logic [3:0] char_bits_base = 4'h5;

	typedef enum logic [1:0] {
		par_with = 2'h0,
		par_force = 2'h1,
		par_none = 2'h2,
		par_multidrop = 2'h3
	} parity_mode_type;

	typedef struct packed {
		logic brk;
		logic framing;
		logic parity;
		logic overrun;
	} rx_status_type;

	typedef struct packed {
		logic watchdog_en;
		logic rx_thr_hi;
		logic [1:0] tx_thr;
		logic baud_ext2;
		logic baud_ext1;
		logic rts_by_rx;
		logic irq_on_full;
		logic block_err;
		parity_mode_type parity_mode;
		logic parity_odd;
		logic [3:0] char_bits;
	} chan_cfg_type;

endpackage : uart_mode_pkg

// *** rtl/mode_reg_bank.sv ***
// the two mode registers of one channel with their read views
module mode_reg_bank #(
	parameter bit is_chan_b = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// write strobes and data
	input wire logic wr_mode0,
	input wire logic wr_mode1,
	input wire logic [7:0] wdata,
	// stored values and read views
	output logic [7:0] mode0_q,
	output logic [7:0] mode1_q,
	output logic [7:0] mode0_view,
	output logic [7:0] mode1_view
);

	wire [7:0] store_mask;
	wire [7:0] read_one;
	wire [7:0] mode0_d;
	wire [7:0] mode1_d;

	// bit 3 is not kept at all; channel b also drops its low nibble
	assign store_mask = is_chan_b ? uart_mode_pkg::mr0_store_b
		: uart_mode_pkg::mr0_store_a; // RULE_05
	assign read_one = is_chan_b ? uart_mode_pkg::mr0_read_one_b
		: uart_mode_pkg::mr0_read_one_a; // RULE_03
	assign mode0_d = wr_mode0 ? (wdata & store_mask) : mode0_q;
	assign mode1_d = wr_mode1 ? wdata : mode1_q;
	assign mode0_view = mode0_q | read_one; // RULE_03 RULE_05
	assign mode1_view = mode1_q;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			mode0_q <= uart_mode_pkg::mr0_reset;
			mode1_q <= uart_mode_pkg::mr1_reset;
		end
		else if (clk_en)
		begin
			mode0_q <= mode0_d;
			mode1_q <= mode1_d;
		end
	end

endmodule : mode_reg_bank

// *** rtl/rx_error_tracker.sv ***
// per-channel receive status: multidrop tag placement and block errors
module rx_error_tracker (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// mode
	input wire logic block_err,
	input wire logic multidrop,
	// received characters
	input wire logic rx_char_push,
	input wire uart_mode_pkg::rx_status_type rx_char_status,
	input wire logic rx_ad_tag,
	input wire uart_mode_pkg::rx_status_type head_status,
	// clears
	input wire logic err_reset_cmd,
	input wire logic rx_reset,
	// results
	output uart_mode_pkg::rx_status_type status_entry_q,
	output uart_mode_pkg::rx_status_type reported_q
);

	uart_mode_pkg::rx_status_type entry_d;
	uart_mode_pkg::rx_status_type acc_q;
	uart_mode_pkg::rx_status_type acc_d;
	uart_mode_pkg::rx_status_type push_bits;
	wire clear_acc;

	// tag takes the parity slot in multidrop
	always_comb
	begin
		entry_d = rx_char_status;
		if (multidrop)
			entry_d.parity = rx_ad_tag; // RULE_12
	end

	assign clear_acc = err_reset_cmd | rx_reset;
	assign push_bits = rx_char_push ? entry_d : '0;
	// an error landing on the clear cycle survives the clear
	assign acc_d = (clear_acc ? '0 : acc_q) | push_bits; // RULE_08

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			acc_q <= '0;
			status_entry_q <= '0;
			reported_q <= '0;
		end
		else if (clk_en)
		begin
			acc_q <= acc_d;
			if (rx_char_push)
				status_entry_q <= entry_d;
			reported_q <= block_err ? acc_d : head_status; // RULE_07
		end
	end

endmodule : rx_error_tracker

// *** rtl/uart_mode_config.sv ***
// channel mode configuration registers of a dual uart
// Operation
// RULE_01: mode0 bit 7 enables receiver watchdog
// RULE_02: mode0 bit 6 rx threshold, 5:4 tx
// RULE_03: bits 3,1 written zero; bit 3 reads one
// RULE_04: mode0 bits 2,0 pick extended baud tables
// RULE_05: channel b mode0 low nibble reads ones
// RULE_06: mode1 bit 6 picks receive interrupt source
// RULE_07: mode1 bit 5 char or block errors
// RULE_08: block errors held until reset command
// RULE_09: mode1 bits 4:3 parity mode, 2 type
// RULE_10: mode1 bit 7 lets receiver drive rts
// RULE_11: mode1 bits 1:0 give five-eight data bits
// RULE_12: multidrop tag lands in parity status slot
module uart_mode_config #(
	parameter int data_w = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clk_en,
	// register bus
	input wire logic [3:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [data_w-1:0] reg_wdata,
	input wire logic [1:0] mode_ptr,
	output logic [data_w-1:0] reg_rdata_q,
	// receiver events, index 0 channel a, 1 channel b
	input wire logic [1:0] receive_char_available,
	input wire logic [1:0] receive_fifo_full,
	input wire logic [1:0] rx_char_push,
	input wire uart_mode_pkg::rx_status_type [1:0] rx_char_status,
	input wire logic [1:0] rx_ad_tag,
	input wire uart_mode_pkg::rx_status_type [1:0] head_status,
	input wire logic [1:0] err_reset_cmd,
	input wire logic [1:0] rx_reset,
	// configuration and status
	output uart_mode_pkg::chan_cfg_type [1:0] cfg_q,
	output logic [1:0] rx_irq_q,
	output logic [1:0] rts_assert_q,
	output uart_mode_pkg::rx_status_type [1:0] status_entry_q,
	output uart_mode_pkg::rx_status_type [1:0] reported_err_q
);

	if (data_w != 8)
	begin : g_bad_width
		$error("uart_mode_config: data_w must be 8");
	end

	function automatic uart_mode_pkg::chan_cfg_type decode_cfg(
		input logic [7:0] m0,
		input logic [7:0] m1
	);
		uart_mode_pkg::chan_cfg_type c;
		c.watchdog_en = m0[uart_mode_pkg::mr0_watchdog_bit]; // RULE_01
		c.rx_thr_hi = m0[uart_mode_pkg::mr0_rx_thr_bit]; // RULE_02
		c.tx_thr = {m0[uart_mode_pkg::mr0_tx_thr_hi],
			m0[uart_mode_pkg::mr0_tx_thr_lo]}; // RULE_02
		c.baud_ext2 = m0[uart_mode_pkg::mr0_ext2_bit]; // RULE_04
		c.baud_ext1 = m0[uart_mode_pkg::mr0_ext1_bit]; // RULE_04
		c.rts_by_rx = m1[uart_mode_pkg::mr1_rts_bit]; // RULE_10
		c.irq_on_full = m1[uart_mode_pkg::mr1_rx_int_bit]; // RULE_06
		c.block_err = m1[uart_mode_pkg::mr1_err_mode_bit]; // RULE_07
		c.parity_mode = uart_mode_pkg::parity_mode_type'(
			{m1[uart_mode_pkg::mr1_par_hi],
			m1[uart_mode_pkg::mr1_par_lo]}); // RULE_09
		c.parity_odd = m1[uart_mode_pkg::mr1_par_type_bit]; // RULE_09
		c.char_bits = uart_mode_pkg::char_bits_base + {2'b00,
			m1[uart_mode_pkg::mr1_len_hi],
			m1[uart_mode_pkg::mr1_len_lo]}; // RULE_11
		return c;
	endfunction : decode_cfg

	// address decode
	wire sel_a;
	wire sel_b;
	wire [1:0] chan_sel;
	assign sel_a = reg_addr == uart_mode_pkg::addr_mode_a;
	assign sel_b = reg_addr == uart_mode_pkg::addr_mode_b;
	assign chan_sel = {sel_b, sel_a};

	wire [7:0] mode0_q [2];
	wire [7:0] mode1_q [2];
	wire [7:0] mode0_view [2];
	wire [7:0] mode1_view [2];
	wire [7:0] chan_view [2];
	wire [data_w-1:0] rdata_d;
	uart_mode_pkg::chan_cfg_type cfg_d [2];
	wire [1:0] rx_irq_d;
	wire [1:0] rts_d;

	for (genvar i = 0; i < 2; i++)
	begin : g_chan
		wire wr_any;
		wire wr_mode0;
		wire wr_mode1;

		// pointer steps are handled outside; it only picks the target here
		assign wr_any = reg_wr & chan_sel[i];
		assign wr_mode0 = wr_any & (mode_ptr[i] == uart_mode_pkg::ptr_mode0);
		assign wr_mode1 = wr_any & (mode_ptr[i] == uart_mode_pkg::ptr_mode1);

		mode_reg_bank #(
			.is_chan_b(i == 1)
		) u_bank (
			.core_clk(core_clk),
			.rstn(rstn),
			.clk_en(clk_en),
			.wr_mode0(wr_mode0),
			.wr_mode1(wr_mode1),
			.wdata(reg_wdata),
			.mode0_q(mode0_q[i]),
			.mode1_q(mode1_q[i]),
			.mode0_view(mode0_view[i]),
			.mode1_view(mode1_view[i])
		);

		assign chan_view[i] = (mode_ptr[i] == uart_mode_pkg::ptr_mode1)
			? mode1_view[i] : mode0_view[i];
		assign cfg_d[i] = decode_cfg(mode0_q[i], mode1_q[i]);
		assign rx_irq_d[i] = cfg_d[i].irq_on_full ? receive_fifo_full[i]
			: receive_char_available[i]; // RULE_06
		// with rts control off the request stays asserted
		assign rts_d[i] = cfg_d[i].rts_by_rx ? !receive_fifo_full[i]
			: 1'b1; // RULE_10

		rx_error_tracker u_err (
			.core_clk(core_clk),
			.rstn(rstn),
			.clk_en(clk_en),
			.block_err(cfg_d[i].block_err),
			.multidrop(cfg_d[i].parity_mode == uart_mode_pkg::par_multidrop),
			.rx_char_push(rx_char_push[i]),
			.rx_char_status(rx_char_status[i]),
			.rx_ad_tag(rx_ad_tag[i]),
			.head_status(head_status[i]),
			.err_reset_cmd(err_reset_cmd[i]),
			.rx_reset(rx_reset[i]),
			.status_entry_q(status_entry_q[i]),
			.reported_q(reported_err_q[i])
		);
	end

	// other addresses belong to neighbouring blocks and read as zero here
	assign rdata_d = sel_a ? chan_view[0]
		: sel_b ? chan_view[1]
		: uart_mode_pkg::unmapped_read;

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata_q <= '0;
			cfg_q <= '0;
			rx_irq_q <= '0;
			rts_assert_q <= '0;
		end
		else if (clk_en)
		begin
			if (reg_rd)
				reg_rdata_q <= rdata_d;
			cfg_q[0] <= cfg_d[0];
			cfg_q[1] <= cfg_d[1];
			rx_irq_q <= rx_irq_d;
			rts_assert_q <= rts_d;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	sequence s_rd_a0;
		clk_en && reg_rd && sel_a && mode_ptr[0] == uart_mode_pkg::ptr_mode0;
	endsequence

	sequence s_rd_b0;
		clk_en && reg_rd && sel_b && mode_ptr[1] == uart_mode_pkg::ptr_mode0;
	endsequence

	sequence s_wr_a0;
		clk_en && reg_wr && sel_a && mode_ptr[0] == uart_mode_pkg::ptr_mode0;
	endsequence

	sequence s_wr_a1;
		clk_en && reg_wr && sel_a && mode_ptr[0] == uart_mode_pkg::ptr_mode1;
	endsequence

	// a write reaches cfg_q two enabled edges later
	sequence s_cfg_a0;
		s_wr_a0 ##1 clk_en;
	endsequence

	sequence s_cfg_a1;
		s_wr_a1 ##1 clk_en;
	endsequence

	sequence s_wr_b1;
		clk_en && reg_wr && sel_b && mode_ptr[1] == uart_mode_pkg::ptr_mode1;
	endsequence

	sequence s_cfg_b1;
		s_wr_b1 ##1 clk_en;
	endsequence

	a_bit3_reads_one: assert property ( // RULE_03
		s_rd_a0 |=> reg_rdata_q[uart_mode_pkg::mr0_dont_care_bit])
		else $error("mode0 bit 3 did not read as one");

	a_chanb_low_ones: assert property ( // RULE_05
		s_rd_b0 |=> (reg_rdata_q & uart_mode_pkg::mr0_read_one_b)
			== uart_mode_pkg::mr0_read_one_b)
		else $error("channel b mode0 low nibble not all ones");

	a_watchdog_follows: assert property ( // RULE_01
		s_cfg_a0 |=> cfg_q[0].watchdog_en
			== $past(reg_wdata[uart_mode_pkg::mr0_watchdog_bit], 2))
		else $error("watchdog enable does not follow write");

	a_thresholds_follow: assert property ( // RULE_02
		s_cfg_a0 |=> cfg_q[0].tx_thr == $past(reg_wdata[5:4], 2)
			&& cfg_q[0].rx_thr_hi == $past(reg_wdata[6], 2))
		else $error("interrupt threshold selects do not follow write");

	a_baud_tables: assert property ( // RULE_04
		s_cfg_a0 |=> {cfg_q[0].baud_ext2, cfg_q[0].baud_ext1}
			== {$past(reg_wdata[2], 2), $past(reg_wdata[0], 2)})
		else $error("baud table selects do not follow write");

	a_chanb_no_ext: assert property ( // RULE_05
		!cfg_q[1].baud_ext1 && !cfg_q[1].baud_ext2)
		else $error("channel b reserved bits took effect");

	a_err_mode: assert property ( // RULE_07
		s_cfg_a1 |=> cfg_q[0].block_err == $past(reg_wdata[5], 2))
		else $error("error mode does not follow write");

	a_parity_fields: assert property ( // RULE_09
		s_cfg_a1 |=> cfg_q[0].parity_mode == $past(reg_wdata[4:3], 2)
			&& cfg_q[0].parity_odd == $past(reg_wdata[2], 2))
		else $error("parity fields do not follow write");

	a_char_length: assert property ( // RULE_11
		s_cfg_a1 |=> cfg_q[0].char_bits == uart_mode_pkg::char_bits_base
			+ {2'b00, $past(reg_wdata[1:0], 2)})
		else $error("character length decode wrong");

	a_irq_source: assert property ( // RULE_06
		clk_en |=> rx_irq_q[0] == ($past(cfg_d[0].irq_on_full)
			? $past(receive_fifo_full[0])
			: $past(receive_char_available[0])))
		else $error("receive interrupt source wrong");

	a_rts_on_full: assert property ( // RULE_10
		clk_en && cfg_d[0].rts_by_rx && receive_fifo_full[0]
			|=> !rts_assert_q[0])
		else $error("rts still asserted with full fifo");

	a_block_hold: assert property ( // RULE_08
		clk_en && cfg_d[0].block_err && $past(cfg_d[0].block_err)
			&& reported_err_q[0].framing
			&& !err_reset_cmd[0] && !rx_reset[0] |=> reported_err_q[0].framing)
		else $error("block error dropped without reset");

	a_block_clear: assert property ( // RULE_08
		clk_en && cfg_d[0].block_err && err_reset_cmd[0] && !rx_char_push[0]
			|=> reported_err_q[0] == '0)
		else $error("error reset did not clear block errors");

	a_multidrop_tag: assert property ( // RULE_12
		clk_en && rx_char_push[0]
			&& cfg_d[0].parity_mode == uart_mode_pkg::par_multidrop
			|=> status_entry_q[0].parity == $past(rx_ad_tag[0]))
		else $error("multidrop tag not in parity slot");

	a_parity_b: assert property ( // RULE_09
		s_cfg_b1 |=> cfg_q[1].parity_mode == $past(reg_wdata[4:3], 2)
			&& cfg_q[1].parity_odd == $past(reg_wdata[2], 2))
		else $error("channel b parity fields do not follow write");

	a_irq_source_b: assert property ( // RULE_06
		clk_en |=> rx_irq_q[1] == ($past(cfg_d[1].irq_on_full)
			? $past(receive_fifo_full[1])
			: $past(receive_char_available[1])))
		else $error("channel b receive interrupt source wrong");

	// rts must come back once the fifo has room again
	a_rts_with_room: assert property ( // RULE_10
		clk_en && !(cfg_d[0].rts_by_rx && receive_fifo_full[0])
			|=> rts_assert_q[0])
		else $error("rts dropped while fifo had room");

	a_unmapped_zero: assert property (
		clk_en && reg_rd && !sel_a && !sel_b
			|=> reg_rdata_q == uart_mode_pkg::unmapped_read)
		else $error("unmapped address did not read as zero");

	// software may poll the data late, so it stands until the next read
	a_rdata_stands: assert property (
		clk_en && !reg_rd |=> $stable(reg_rdata_q))
		else $error("read data changed without a read");

	// a low enable must freeze cfg_q, reported_err_q and rx_irq_q too, not only the bus side
	a_enable_freeze: assert property (
		!clk_en |=> $stable(cfg_q) && $stable(reg_rdata_q)
			&& $stable(reported_err_q) && $stable(rx_irq_q))
		else $error("state moved while clock enable was low");

endmodule : uart_mode_config

// *** test/host_model.sv ***
// host processor model driving the parallel register bus
module host_model (
	// clock
	input wire logic core_clk,
	// register bus
	output logic [3:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic [1:0] mode_ptr,
	input wire logic [7:0] reg_rdata_q
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		reg_addr = 4'h2;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		mode_ptr = 2'h0;
	end

	// one single-cycle access; data scrambled after, so stale bytes never
	// pass for fresh ones
	task automatic xfer(input logic [3:0] a, input logic p, input logic w,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk);
		reg_addr = a;
		mode_ptr[a[3]] = p;
		reg_wr = w;
		reg_rd = !w;
		reg_wdata = p ? d : d & 8'hf5;
		@(negedge core_clk);
		q = reg_rdata_q;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = ~d;
		reg_addr = 4'h2;
	endtask : xfer
endmodule : host_model

// *** test/tb_uart_mode_config.sv ***
// self-checking bench for the channel mode registers
module tb_uart_mode_config;
	timeunit 1ns;
	timeprecision 1ps;

	logic core_clk;
	logic rstn;
	logic clk_en;
	logic [3:0] reg_addr;
	logic reg_rd;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic [1:0] mode_ptr;
	logic [7:0] reg_rdata_q;
	logic [1:0] receive_char_available;
	logic [1:0] receive_fifo_full;
	logic [1:0] rx_char_push;
	uart_mode_pkg::rx_status_type [1:0] rx_char_status;
	logic [1:0] rx_ad_tag;
	uart_mode_pkg::rx_status_type [1:0] head_status;
	logic [1:0] err_reset_cmd;
	logic [1:0] rx_reset;
	uart_mode_pkg::chan_cfg_type [1:0] cfg_q;
	logic [1:0] rx_irq_q;
	logic [1:0] rts_assert_q;
	uart_mode_pkg::rx_status_type [1:0] status_entry_q;
	uart_mode_pkg::rx_status_type [1:0] reported_err_q;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;
	logic [7:0] q;
	localparam logic [3:0] ma = uart_mode_pkg::addr_mode_a;
	localparam logic [3:0] mb = uart_mode_pkg::addr_mode_b;

	host_model host (
		.core_clk(core_clk),
		.reg_addr(reg_addr),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.mode_ptr(mode_ptr),
		.reg_rdata_q(reg_rdata_q)
	);

	uart_mode_config #(
		.data_w(8)
	) dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.clk_en(clk_en),
		.reg_addr(reg_addr),
		.reg_rd(reg_rd),
		.reg_wr(reg_wr),
		.reg_wdata(reg_wdata),
		.mode_ptr(mode_ptr),
		.reg_rdata_q(reg_rdata_q),
		.receive_char_available(receive_char_available),
		.receive_fifo_full(receive_fifo_full),
		.rx_char_push(rx_char_push),
		.rx_char_status(rx_char_status),
		.rx_ad_tag(rx_ad_tag),
		.head_status(head_status),
		.err_reset_cmd(err_reset_cmd),
		.rx_reset(rx_reset),
		.cfg_q(cfg_q),
		.rx_irq_q(rx_irq_q),
		.rts_assert_q(rts_assert_q),
		.status_entry_q(status_entry_q),
		.reported_err_q(reported_err_q)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic complete_run;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	// hang guard well above the hundred or so cycles the run needs
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s exp %h got %h", what, exp, got);
		end
	endtask : chk

	// extra edge so the decoded config has landed too
	task automatic wr(input logic [3:0] a, input logic p, input logic [7:0] d);
		host.xfer(a, p, 1'b1, d, q);
		@(negedge core_clk);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic p);
		host.xfer(a, p, 1'b0, 8'h00, q);
	endtask : rd

	function automatic logic [7:0] m0f(uart_mode_pkg::chan_cfg_type c);
		return {2'h0, c.watchdog_en, c.rx_thr_hi, c.tx_thr, c.baud_ext2,
			c.baud_ext1};
	endfunction : m0f

	task automatic push(input logic [3:0] st, input logic tag);
		@(negedge core_clk);
		rx_char_push[0] = 1'b1;
		rx_char_status[0] = st;
		rx_ad_tag[0] = tag;
		@(negedge core_clk);
		rx_char_push[0] = 1'b0;
		rx_char_status[0] = ~st;
		rx_ad_tag[0] = ~tag;
	endtask : push

	task automatic t_reset;
		rd(ma, 1'b0);
		chk("mode0 a rst", 8'h08, q);
		rd(mb, 1'b0);
		chk("mode0 b rst", 8'h0f, q);
		rd(mb, 1'b1);
		chk("mode1 b rst", 8'h00, q);
		chk("len rst", 8'h05, {4'h0, cfg_q[0].char_bits});
		rd(4'h1, 1'b0);
		chk("unmapped", 8'h00, q);
	endtask : t_reset

	task automatic t_mode0;
		logic [7:0] w[2] = '{8'h94, 8'h61};
		logic [7:0] r[2] = '{8'h9c, 8'h69};
		logic [7:0] c[2] = '{8'h26, 8'h19};
		for (int i = 0; i < 2; i++)
		begin
			wr(ma, 1'b0, w[i]);
			rd(ma, 1'b0);
			chk("mode0 a", r[i], q);
			chk("cfg0 a", c[i], m0f(cfg_q[0]));
		end
		wr(mb, 1'b0, 8'h94);
		rd(mb, 1'b0);
		chk("mode0 b", 8'h9f, q);
		chk("cfg0 b", 8'h24, m0f(cfg_q[1]));
	endtask : t_mode0

	task automatic t_freeze;
		clk_en = 1'b0;
		wr(ma, 1'b0, 8'h80);
		clk_en = 1'b1;
		rd(ma, 1'b0);
		chk("freeze mode0", 8'h69, q);
		chk("freeze cfg", 8'h19, m0f(cfg_q[0]));
	endtask : t_freeze

	task automatic t_mode1;
		logic [1:0] k;
		logic [3:0] a;
		for (int i = 0; i < 4; i++)
		begin
			k = 2'(i);
			a = k[0] ? mb : ma;
			wr(a, 1'b1, {3'h0, k, k[0], ~k});
			rd(a, 1'b1);
			chk("mode1", {3'h0, k, k[0], ~k}, q);
			chk("par cfg", {5'h0, cfg_q[k[0]].parity_mode,
				cfg_q[k[0]].parity_odd}, {5'h0, k, k[0]});
			chk("len cfg", {4'h0, 4'h5 + {2'h0, ~k}},
				{4'h0, cfg_q[k[0]].char_bits});
		end
	endtask : t_mode1

	task automatic t_irq_rts;
		wr(ma, 1'b1, 8'hc3);
		receive_char_available = 2'h3;
		repeat (2) @(negedge core_clk);
		chk("irq avail", 8'h00, {7'h0, rx_irq_q[0]});
		chk("rts room", 8'h01, {7'h0, rts_assert_q[0]});
		chk("irq b rdy", 8'h01, {7'h0, rx_irq_q[1]});
		receive_fifo_full[0] = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("irq full", 8'h01, {7'h0, rx_irq_q[0]});
		chk("rts full", 8'h00, {7'h0, rts_assert_q[0]});
		receive_fifo_full[0] = 1'b0;
		repeat (2) @(negedge core_clk);
		chk("rts again", 8'h01, {7'h0, rts_assert_q[0]});
		wr(ma, 1'b1, 8'h03);
		@(negedge core_clk);
		chk("irq rdy", 8'h01, {7'h0, rx_irq_q[0]});
		receive_char_available = 2'h0;
	endtask : t_irq_rts

	task automatic t_errors;
		wr(ma, 1'b1, 8'h20);
		push(4'h4, 1'b0);
		push(4'h1, 1'b0);
		repeat (3) @(negedge core_clk);
		chk("block hold", 8'h05, {4'h0, reported_err_q[0]});
		err_reset_cmd[0] = 1'b1;
		@(negedge core_clk);
		err_reset_cmd[0] = 1'b0;
		@(negedge core_clk);
		chk("err reset", 8'h00, {4'h0, reported_err_q[0]});
		push(4'h8, 1'b0);
		chk("block set", 8'h08, {4'h0, reported_err_q[0]});
		rx_reset[0] = 1'b1;
		@(negedge core_clk);
		rx_reset[0] = 1'b0;
		@(negedge core_clk);
		chk("rx reset", 8'h00, {4'h0, reported_err_q[0]});
		wr(ma, 1'b1, 8'h00);
		head_status[0] = 4'h2;
		repeat (2) @(negedge core_clk);
		chk("char head", 8'h02, {4'h0, reported_err_q[0]});
		wr(ma, 1'b1, 8'h18);
		push(4'h0, 1'b1);
		chk("tag set", 8'h02, {4'h0, status_entry_q[0]});
		push(4'h2, 1'b0);
		chk("tag clear", 8'h00, {4'h0, status_entry_q[0]});
	endtask : t_errors

	task automatic t_midrun_reset;
		rstn = 1'b0;
		@(negedge core_clk);
		chk("rts in rst", 8'h00, {6'h0, rts_assert_q});
		rstn = 1'b1;
		rd(mb, 1'b1);
		chk("mode1 b rerst", 8'h00, q);
		chk("rts rerst", 8'h03, {6'h0, rts_assert_q});
	endtask : t_midrun_reset

	initial
	begin
		rstn = 1'b0;
		clk_en = 1'b1;
		receive_char_available = 2'h0;
		receive_fifo_full = 2'h0;
		rx_char_push = 2'h0;
		rx_char_status = '0;
		rx_ad_tag = 2'h0;
		head_status = '0;
		err_reset_cmd = 2'h0;
		rx_reset = 2'h0;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		rstn = 1'b1;
		t_reset();
		t_mode0();
		t_freeze();
		t_mode1();
		t_irq_rts();
		t_errors();
		t_midrun_reset();
		complete_run();
	end
endmodule : tb_uart_mode_config
